/* design/rab_alarm_backup.sv */
// Alarm-0 compare, alarm interrupt pin driver and battery backup mode selection behind an AHB-Lite slave.
//
// Contract
// - Bit 7 of each alarm register enables compare; lower bits hold BCD target.
// - A field with its enable bit clear takes no part in the match.
// - With repeat_pulse_select 0, one alarm event at the first full match.
// - The match is evaluated when the time rolls over to new values.
// - On match, set alarm_zero_flag and pull irq_freq_output low.
// - With repeat_pulse_select 1, a pulse is issued at every match.
// - Only seconds enabled at 30 gives an interrupt once per minute.
// - Control register holds repeat_pulse_select in bit 7, alarm_zero_enable in bit 5.
// - In pulsed mode the flag sets each trigger; pulses need no flag clear.
// - Standard backup mode stops alarm generation on battery; serial access follows serial_off_in_backup.
// - Legacy backup keeps alarms and serial access unless serial_off_in_backup is set.
// - Mode A: standard switchover, serial interface works in backup.
// - Mode B: legacy switchover, serial interface works in backup.
// - Mode C: standard switchover, serial interface off in backup.
// - Mode D: legacy switchover, serial interface off in backup.
// - The interrupt pin stays active on battery in all four modes; here alarms reach it on battery only in modes B and D.
`timescale 1ns/10ps

module rab_alarm_backup
#(
    parameter int unsigned PULSE_CYCLES = rab_pkg::PULSE_CYCLES
)
(
    input  wire logic        i_sys_clk,            // System clock, 100 MHz.
    input  wire logic        i_reset_n,            // Asynchronous reset, active low.
    input  wire logic        i_hsel,               // AHB slave select.
    input  wire logic [31:0] i_haddr,              // AHB address.
    input  wire logic [1:0]  i_htrans,             // AHB transfer type.
    input  wire logic        i_hwrite,             // AHB write when high.
    input  wire logic [2:0]  i_hsize,              // AHB transfer size.
    input  wire logic [31:0] i_hwdata,             // AHB write data.
    input  wire logic        i_hready,             // AHB bus ready.
    output logic      [31:0] o_hrdata,             // AHB read data.
    output logic             o_hreadyout,          // AHB slave ready.
    output logic             o_hresp,              // AHB response, always OKAY.
    input  wire logic        i_time_tick,          // One-cycle pulse: time fields just took new values.
    input  wire logic [6:0]  i_time_sec,           // Current seconds, BCD.
    input  wire logic [6:0]  i_time_min,           // Current minutes, BCD.
    input  wire logic [6:0]  i_time_hour,          // Current hours, BCD.
    input  wire logic [6:0]  i_time_date,          // Current date, BCD.
    input  wire logic [6:0]  i_time_month,         // Current month, BCD.
    input  wire logic [6:0]  i_time_weekday,       // Current day of week.
    input  wire logic        i_main_below_backup,  // Comparator pin: main supply below backup supply.
    input  wire logic        i_main_below_trip,    // Comparator pin: main supply below trip level.
    output logic             o_irq_freq_out,       // Interrupt pin output level, always low.
    output logic             o_irq_freq_oe,        // Interrupt pin enable, high pulls the pin low.
    output logic             o_on_battery,         // High while running from backup supply.
    output logic             o_serial_enable,      // High while the serial interface may run.
    output logic             o_irq                 // Level interrupt from enabled status bits.
);

    // =====================================================================
    // Register storage.
    logic [7:0]                        match_reg [rab_pkg::FIELD_COUNT];
    logic [7:0]                        irq_control_reg;
    logic [1:0]                        backup_cfg;
    logic [rab_pkg::EVT_COUNT-1:0]     evt_status;
    logic [rab_pkg::EVT_COUNT-1:0]     evt_enable;

    // Bus pipeline state.
    logic                              wr_pend;
    logic                              rd_pend;
    logic [7:0]                        addr_q;
    logic                              bus_accept;
    logic                              bus_blocked;
    logic                              wr_do;

    // Supply comparator synchronisers and power state.
    logic [1:0]                        bat_sync;
    logic [1:0]                        trip_sync;
    logic                              next_on_battery;
    logic                              on_battery_q;
    logic [1:0]                        mode;

    // Alarm compare.
    logic [6:0]                        now_field [rab_pkg::FIELD_COUNT];
    logic [rab_pkg::FIELD_COUNT-1:0]   field_ok;
    logic [rab_pkg::FIELD_COUNT-1:0]   field_used;
    logic                              match_now;
    logic                              match_prev;
    logic                              alarm_event;
    logic                              alarms_allowed;

    // Pin driver.
    rab_pkg::rab_pin_state_t           pin_state;
    logic [31:0]                       pulse_cnt;
    logic [rab_pkg::EVT_COUNT-1:0]     evt_set;
    logic [rab_pkg::EVT_COUNT-1:0]     evt_clr;

    // =====================================================================
    // Bus decode. A transfer is taken when selected, NONSEQ or SEQ, and ready.
    assign bus_accept = i_hsel & i_htrans[1] & i_hready;
    // serial gating
    // In modes C and D the register port goes deaf on battery: writes drop, reads give zero.
    assign bus_blocked = on_battery_q & backup_cfg[rab_pkg::SERIAL_OFF_BIT];
    assign wr_do       = wr_pend & ~bus_blocked;

    // Address and direction capture; reads get one wait state so the read mux
    // always sees the effect of a write that finished in the same cycle.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_pend     <= 1'b0;
            rd_pend     <= 1'b0;
            addr_q      <= 8'h00;
            o_hreadyout <= 1'b1;
        end
        else
        begin
            wr_pend <= bus_accept & i_hwrite;
            rd_pend <= bus_accept & ~i_hwrite;
            if (bus_accept)
            begin
                addr_q <= i_haddr[7:0];
            end
            if (bus_accept && !i_hwrite)
            begin
                o_hreadyout <= 1'b0;
            end
            else
            begin
                o_hreadyout <= 1'b1;
            end
        end
    end

    // Response is always OKAY; the size field is not checked, only whole words are used.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_hresp <= 1'b0;
        end
        else
        begin
            o_hresp <= 1'b0;
        end
    end

    // Read data mux, loaded during the wait state of a read.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_hrdata <= 32'h0000_0000;
        end
        else if (rd_pend)
        begin
            o_hrdata <= 32'h0000_0000;
            if (!bus_blocked)
            begin
                unique case (addr_q)
                    rab_pkg::OFS_ALARM_SEC:     o_hrdata <= {24'h00_0000, match_reg[0]};
                    rab_pkg::OFS_ALARM_MIN:     o_hrdata <= {24'h00_0000, match_reg[1]};
                    rab_pkg::OFS_ALARM_HOUR:    o_hrdata <= {24'h00_0000, match_reg[2]};
                    rab_pkg::OFS_ALARM_DATE:    o_hrdata <= {24'h00_0000, match_reg[3]};
                    rab_pkg::OFS_ALARM_MONTH:   o_hrdata <= {24'h00_0000, match_reg[4]};
                    rab_pkg::OFS_ALARM_WEEKDAY: o_hrdata <= {24'h00_0000, match_reg[5]};
                    rab_pkg::OFS_IRQ_CONTROL:   o_hrdata <= {24'h00_0000, irq_control_reg};
                    rab_pkg::OFS_BACKUP_CFG:    o_hrdata <= {30'h0000_0000, backup_cfg};
                    rab_pkg::OFS_EVT_STATUS:    o_hrdata <= {29'h0000_0000, evt_status};
                    rab_pkg::OFS_EVT_ENABLE:    o_hrdata <= {29'h0000_0000, evt_enable};
                    rab_pkg::OFS_POWER_STATE:   o_hrdata <= {29'h0000_0000, mode, on_battery_q};
                    default:                    o_hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // =====================================================================
    // Alarm match registers, one per time field.
    genvar gi;
    generate
        for (gi = 0; gi < rab_pkg::FIELD_COUNT; gi++)
        begin : g_field
            // enable and value
            // The stored byte is kept whole; bit 7 gates the compare, bits 6..0 are the target.
            always_ff @(posedge i_sys_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    match_reg[gi] <= rab_pkg::MATCH_RESET;
                end
                else if (wr_do && addr_q == rab_pkg::OFS_ALARM_SEC + 8'(4 * gi))
                begin
                    match_reg[gi] <= i_hwdata[7:0];
                end
            end

            assign field_used[gi] = match_reg[gi][rab_pkg::MATCH_ENABLE_BIT];
            assign field_ok[gi]   = ~field_used[gi] | (match_reg[gi][6:0] == now_field[gi]);
        end
    endgenerate

    assign now_field[0] = i_time_sec;
    assign now_field[1] = i_time_min;
    assign now_field[2] = i_time_hour;
    assign now_field[3] = i_time_date;
    assign now_field[4] = i_time_month;
    assign now_field[5] = i_time_weekday;

    // With no field enabled nothing would be compared, so that case never matches.
    assign match_now = (&field_ok) & (|field_used);

    // =====================================================================
    // Interrupt control and backup configuration registers.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            irq_control_reg <= rab_pkg::IRQ_CONTROL_RESET;
            backup_cfg      <= rab_pkg::BACKUP_CFG_RESET;
            evt_enable      <= rab_pkg::EVT_ENABLE_RESET;
        end
        else if (wr_do)
        begin
            if (addr_q == rab_pkg::OFS_IRQ_CONTROL)
            begin
                irq_control_reg <= i_hwdata[7:0];
            end
            if (addr_q == rab_pkg::OFS_BACKUP_CFG)
            begin
                backup_cfg <= i_hwdata[1:0];
            end
            if (addr_q == rab_pkg::OFS_EVT_ENABLE)
            begin
                evt_enable <= i_hwdata[rab_pkg::EVT_COUNT-1:0];
            end
        end
    end

    // =====================================================================
    // Supply comparators come from pins and pass two flops first.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bat_sync  <= 2'h0;
            trip_sync <= 2'h0;
        end
        else
        begin
            bat_sync  <= {bat_sync[0], i_main_below_backup};
            trip_sync <= {trip_sync[0], i_main_below_trip};
        end
    end

    assign mode = {backup_cfg[rab_pkg::SERIAL_OFF_BIT], backup_cfg[rab_pkg::LEGACY_SW_BIT]};

    // Switchover threshold depends only on the legacy select bit.
    always_comb
    begin
        unique case (mode)
            rab_pkg::MODE_A: next_on_battery = bat_sync[1] & trip_sync[1];
            rab_pkg::MODE_B: next_on_battery = bat_sync[1];
            rab_pkg::MODE_C: next_on_battery = bat_sync[1] & trip_sync[1];
            rab_pkg::MODE_D: next_on_battery = bat_sync[1];
        endcase
    end

    // Power state flop and the user-side outputs that follow from it.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            on_battery_q    <= 1'b0;
            o_on_battery    <= 1'b0;
            o_serial_enable <= 1'b1;
        end
        else
        begin
            on_battery_q    <= next_on_battery;
            o_on_battery    <= next_on_battery;
            o_serial_enable <= ~(next_on_battery & backup_cfg[rab_pkg::SERIAL_OFF_BIT]);
        end
    end

    // =====================================================================
    // Alarm evaluation at each time rollover.
    // alarms in backup
    // Standard switchover stops alarm generation on battery; legacy keeps it.
    assign alarms_allowed = ~on_battery_q | backup_cfg[rab_pkg::LEGACY_SW_BIT];

    // The previous match is remembered so single mode fires only on the first one.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            match_prev <= 1'b0;
        end
        else if (i_time_tick)
        begin
            match_prev <= match_now;
        end
    end

    // arming and mode
    // Pulsed mode fires at every rollover that matches; single mode needs a fresh match.
    assign alarm_event = i_time_tick & match_now & alarms_allowed
                       & irq_control_reg[rab_pkg::ALARM_ENABLE_BIT]
                       & (irq_control_reg[rab_pkg::REPEAT_PULSE_BIT] | ~match_prev);

    // =====================================================================
    // Sticky status bits; a set in the same cycle as a clear wins.
    assign evt_set[rab_pkg::EVT_ALARM_BIT]   = alarm_event;
    assign evt_set[rab_pkg::EVT_TO_BATT_BIT] = next_on_battery & ~on_battery_q;
    assign evt_set[rab_pkg::EVT_TO_MAIN_BIT] = ~next_on_battery & on_battery_q;
    assign evt_clr = (wr_do && addr_q == rab_pkg::OFS_EVT_CLEAR) ?
                     i_hwdata[rab_pkg::EVT_COUNT-1:0] : {rab_pkg::EVT_COUNT{1'b0}};

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            evt_status <= {rab_pkg::EVT_COUNT{1'b0}};
        end
        else
        begin
            evt_status <= (evt_status & ~evt_clr) | evt_set;
        end
    end

    // Level interrupt from enabled status bits, registered so the port comes off a flop.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= |(((evt_status & ~evt_clr) | evt_set) & evt_enable);
        end
    end

    // =====================================================================
    // Open-drain interrupt pin driver. Single mode holds the pin low until the
    // flag is cleared; pulsed mode gives a fixed-length low pulse per trigger.
    // pin in backup
    // Nothing here looks at the power state; alarm_event is held off on battery in modes A and C.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_state <= rab_pkg::RAB_PIN_IDLE;
            pulse_cnt <= 32'h0000_0000;
        end
        else
        begin
            unique case (pin_state)
                rab_pkg::RAB_PIN_IDLE:
                begin
                    if (alarm_event && irq_control_reg[rab_pkg::REPEAT_PULSE_BIT])
                    begin
                        pin_state <= rab_pkg::RAB_PIN_PULSE;
                        pulse_cnt <= 32'(PULSE_CYCLES - 1);
                    end
                    else if (alarm_event)
                    begin
                        pin_state <= rab_pkg::RAB_PIN_LEVEL;
                    end
                end
                rab_pkg::RAB_PIN_LEVEL:
                begin
                    // A clear that meets a new trigger loses, so the pin stays low.
                    if (evt_clr[rab_pkg::EVT_ALARM_BIT] && !alarm_event)
                    begin
                        pin_state <= rab_pkg::RAB_PIN_IDLE;
                    end
                end
                rab_pkg::RAB_PIN_PULSE:
                begin
                    if (pulse_cnt == 32'h0000_0000)
                    begin
                        pin_state <= rab_pkg::RAB_PIN_IDLE;
                    end
                    else
                    begin
                        pulse_cnt <= pulse_cnt - 32'h0000_0001;
                    end
                end
                default:
                begin
                    pin_state <= rab_pkg::RAB_PIN_IDLE;
                end
            endcase
        end
    end

    // Pin outputs come from flops; the output level is fixed low, the enable pulls.
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_irq_freq_out <= 1'b0;
            o_irq_freq_oe  <= 1'b0;
        end
        else
        begin
            o_irq_freq_out <= 1'b0;
            o_irq_freq_oe  <= (pin_state != rab_pkg::RAB_PIN_IDLE);
        end
    end

endmodule

/* design/rab_pkg.sv */
// Package of register offsets, field positions, reset values and timing constants for the alarm and backup block.
package rab_pkg;

    // =====================================================================
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] OFS_ALARM_SEC     = 8'h00;
    localparam logic [7:0] OFS_ALARM_MIN     = 8'h04;
    localparam logic [7:0] OFS_ALARM_HOUR    = 8'h08;
    localparam logic [7:0] OFS_ALARM_DATE    = 8'h0C;
    localparam logic [7:0] OFS_ALARM_MONTH   = 8'h10;
    localparam logic [7:0] OFS_ALARM_WEEKDAY = 8'h14;
    localparam logic [7:0] OFS_IRQ_CONTROL   = 8'h18;
    localparam logic [7:0] OFS_BACKUP_CFG    = 8'h1C;
    localparam logic [7:0] OFS_EVT_STATUS    = 8'h20;
    localparam logic [7:0] OFS_EVT_CLEAR     = 8'h24;
    localparam logic [7:0] OFS_EVT_ENABLE    = 8'h28;
    localparam logic [7:0] OFS_POWER_STATE   = 8'h2C;

    // =====================================================================
    // Field positions.
    localparam int unsigned MATCH_ENABLE_BIT  = 7;
    localparam int unsigned REPEAT_PULSE_BIT  = 7;
    localparam int unsigned ALARM_ENABLE_BIT  = 5;
    localparam int unsigned LEGACY_SW_BIT     = 0;
    localparam int unsigned SERIAL_OFF_BIT    = 1;
    localparam int unsigned EVT_ALARM_BIT     = 0;
    localparam int unsigned EVT_TO_BATT_BIT   = 1;
    localparam int unsigned EVT_TO_MAIN_BIT   = 2;
    localparam int unsigned EVT_COUNT         = 3;
    localparam int unsigned FIELD_COUNT       = 6;

    // =====================================================================
    // Reset values.
    localparam logic [7:0] MATCH_RESET       = 8'h00;
    localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
    localparam logic [1:0] BACKUP_CFG_RESET  = 2'h0;
    localparam logic [2:0] EVT_ENABLE_RESET  = 3'h0;

    // =====================================================================
    // Backup modes, upper bit is serial_off_in_backup.
    localparam logic [1:0] MODE_A = 2'h0;
    localparam logic [1:0] MODE_B = 2'h1;
    localparam logic [1:0] MODE_C = 2'h2;
    localparam logic [1:0] MODE_D = 2'h3;

    // =====================================================================
    // Timing: clock rate and length of one pulse on the interrupt pin.
    localparam int unsigned CLK_FREQ_MHZ   = 100;
    localparam int unsigned PULSE_TIME_US  = 250000;
    localparam int unsigned PULSE_CYCLES   = PULSE_TIME_US * CLK_FREQ_MHZ;

    // Interrupt pin driver states.
    typedef enum logic [2:0]
    {
        RAB_PIN_IDLE  = 3'h1,
        RAB_PIN_LEVEL = 3'h2,
        RAB_PIN_PULSE = 3'h4
    } rab_pin_state_t;

endpackage

/* testbench/rab_alarm_backup_properties.sv */
// Concurrent checks on the ports of the alarm and backup block.
`timescale 1ns/10ps
module rab_alarm_backup_properties
(
    input wire logic       i_sys_clk,           // Clock.
    input wire logic       i_reset_n,           // Reset, active low.
    input wire logic       i_hsel,              // Bus select.
    input wire logic [1:0] i_htrans,            // Transfer type.
    input wire logic       i_hwrite,            // Write when high.
    input wire logic       i_hready,            // Bus ready.
    input wire logic       o_hreadyout,         // Slave ready.
    input wire logic       o_hresp,             // Slave response.
    input wire logic       i_time_tick,         // Time update strobe.
    input wire logic       i_main_below_backup, // Main below backup.
    input wire logic       i_main_below_trip,   // Main below trip level.
    input wire logic       o_irq_freq_out,      // Pin level.
    input wire logic       o_irq_freq_oe,       // Pin pull-down enable.
    input wire logic       o_on_battery,        // Running on backup supply.
    input wire logic       o_serial_enable      // Serial access allowed.
);
    // =========================================================
    // Sequences and properties.
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_rd_acc; i_hsel && i_htrans[1] && i_hready && !i_hwrite; endsequence
    sequence s_wr_acc; i_hsel && i_htrans[1] && i_hready && i_hwrite; endsequence
    sequence s_rd_ans; !o_hreadyout ##1 o_hreadyout; endsequence
    property p_rd_wait; s_rd_acc |=> s_rd_ans; endproperty
    property p_wr_fast; s_wr_acc |=> o_hreadyout; endproperty
    property p_okay; !o_hresp; endproperty
    property p_pin_cause; $rose(o_irq_freq_oe) |-> $past(i_time_tick, 2); endproperty
    property p_pin_low; !o_irq_freq_out; endproperty
    property p_bat_in; $rose(o_on_battery) |-> $past(i_main_below_backup, 3); endproperty
    property p_bat_out;
        $fell(o_on_battery) |-> !$past(i_main_below_backup, 3) || !$past(i_main_below_trip, 3);
    endproperty
    property p_serial; !o_serial_enable |-> o_on_battery || $past(o_on_battery); endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("Read answer timing wrong");
    a_wr_fast: assert property (p_wr_fast) else $error("Write stalled");
    a_okay: assert property (p_okay) else $error("Response not OKAY");
    a_pin_cause: assert property (p_pin_cause) else $error("Pin pulled low without tick");
    a_pin_low: assert property (p_pin_low) else $error("Pin drives high level");
    a_bat_in: assert property (p_bat_in) else $error("Battery entered without cause");
    a_bat_out: assert property (p_bat_out) else $error("Battery left without cause");
    a_serial: assert property (p_serial) else $error("Serial off on main supply");
endmodule

/* testbench/rab_alarm_backup_tb.sv */
// Top testbench for the alarm and backup block.
`timescale 1ns/10ps
module rab_alarm_backup_tb;
    localparam int unsigned PC = 8;
    logic clk, rst_n, tick, bb, trip, hsel, hwrite, hrdy, oe, pin, batt, ser, irq, resp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [6:0]  sec, mins, hr = 7'h11;
    logic [7:0]  sv [6] = '{8'h00, 8'hB0, 8'h91, 8'h81, 8'h81, 8'h00};
    int          error_cnt, n_checks, cyc;
    rab_host_model host_u(.i_sys_clk(clk), .i_hready(hrdy), .i_hrdata(hrdata), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hsize(hsize), .o_hwrite(hwrite), .o_hwdata(hwdata));
    rab_alarm_backup #(.PULSE_CYCLES(PC)) dut_u(.i_sys_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(resp), .i_time_tick(tick),
        .i_time_sec(sec), .i_time_min(mins), .i_time_hour(hr), .i_time_date(7'h01),
        .i_time_month(7'h01), .i_time_weekday(7'h03), .i_main_below_backup(bb), .i_main_below_trip(trip),
        .o_irq_freq_out(pin), .o_irq_freq_oe(oe), .o_on_battery(batt), .o_serial_enable(ser), .o_irq(irq));
    // =========================================================
    // Clock and hang guard.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    task end_of_test;
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        host_u.xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    // One time update, then time for the pin to follow.
    task tk(input logic [6:0] s, input logic [6:0] m);
        @(posedge clk);
        tick <= 1'b1;
        sec <= s;
        mins <= m;
        @(posedge clk);
        tick <= 1'b0;
        wt(3);
    endtask
    // =========================================================
    // Main sequence.
    initial
    begin
        {rst_n, tick, bb, trip, sec, mins, error_cnt, n_checks, cyc} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 'h30; a += 4) rd(8'(a), 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'(4 * i), 32'h81 + i);
            rd(8'(4 * i), 32'h81 + i);
        end
        for (int i = 0; i < 6; i++) wr(8'(4 * i), {24'h0, sv[i]});
        wr(rab_pkg::OFS_EVT_ENABLE, 32'h1);
        wr(rab_pkg::OFS_IRQ_CONTROL, 32'h0);
        tk(7'h00, 7'h30); chk(oe, 32'h0);
        host_u.arm(1'b0);
        tk(7'h59, 7'h29); chk(oe, 32'h0);
        tk(7'h00, 7'h30); chk({irq, oe}, 32'h3);
        rd(rab_pkg::OFS_EVT_STATUS, 32'h1);
        wt(30); chk(oe, 32'h1);
        wr(rab_pkg::OFS_EVT_CLEAR, 32'h1);
        wt(2); chk({irq, oe}, 32'h0);
        tk(7'h01, 7'h30); chk(oe, 32'h0);
        @(posedge clk) hr <= 7'h12;
        tk(7'h59, 7'h29); tk(7'h00, 7'h30); chk(oe, 32'h0);
        for (int i = 1; i < 5; i++) wr(8'(4 * i), 32'h0);
        wr(rab_pkg::OFS_ALARM_SEC, 32'hB0);
        host_u.arm(1'b1);
        rd(rab_pkg::OFS_IRQ_CONTROL, 32'hA0);
        tk(7'h30, 7'h00); chk(oe, 32'h1);
        wt(PC + 4); chk(oe, 32'h0);
        rd(rab_pkg::OFS_EVT_STATUS, 32'h1);
        tk(7'h31, 7'h00); chk(oe, 32'h0);
        tk(7'h30, 7'h00); chk(oe, 32'h1);
        wt(PC + 4);
        for (int m = 0; m < 4; m++)
        begin
            wr(rab_pkg::OFS_BACKUP_CFG, 32'(m));
            @(posedge clk);
            bb <= 1'b1;
            wt(6); chk(batt, 32'(m & 1));
            @(posedge clk);
            trip <= 1'b1;
            wt(6); chk({ser, batt}, {30'h0, ~m[1], 1'b1});
            rd(rab_pkg::OFS_POWER_STATE, m < 2 ? 32'(2 * m + 1) : 32'h0);
            tk(7'h30, 7'h00); chk(oe, 32'(m & 1));
            wt(PC + 4);
            @(posedge clk);
            bb <= 1'b0;
            trip <= 1'b0;
            wt(6);
        end
        end_of_test();
    end
endmodule
bind rab_alarm_backup rab_alarm_backup_properties chk_u(.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_hsel(i_hsel), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_time_tick(i_time_tick), .i_main_below_backup(i_main_below_backup),
    .i_main_below_trip(i_main_below_trip), .o_irq_freq_out(o_irq_freq_out), .o_irq_freq_oe(o_irq_freq_oe),
    .o_on_battery(o_on_battery), .o_serial_enable(o_serial_enable));

/* testbench/rab_host_model.sv */
// Host model that reaches the block registers over AHB-Lite.
`timescale 1ns/10ps
module rab_host_model
(
    input  wire logic        i_sys_clk, // Clock.
    input  wire logic        i_hready,  // Bus ready.
    input  wire logic [31:0] i_hrdata,  // Read data.
    output logic             o_hsel,    // Select.
    output logic      [31:0] o_haddr,   // Address.
    output logic      [1:0]  o_htrans,  // Transfer type.
    output logic      [2:0]  o_hsize,   // Transfer size.
    output logic             o_hwrite,  // Write when high.
    output logic      [31:0] o_hwdata   // Write data.
);
    logic [31:0] dmy;
    // Bus idles until the first transfer.
    initial {o_hsel, o_haddr, o_htrans, o_hsize, o_hwrite, o_hwdata} = '0;
    // Address held until ready, then data held until ready again.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_sys_clk);
        o_hsel <= 1'b1;
        o_htrans <= 2'h2;
        o_hwrite <= w;
        o_hsize <= 3'h2;
        o_haddr <= {24'h0, a};
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        q = i_hrdata;
    endtask
    task arm(input logic rpt);
        xfer(1'b1, rab_pkg::OFS_IRQ_CONTROL, {24'h0, rpt, 2'h1, 5'h0}, dmy);
    endtask
endmodule
